/* File: hw/svf_core.sv */
// Digital core of a synchronous voltage-to-frequency converter.
// Assumes digitised input codes on the clock domain, static strap pins
// that may change asynchronously, and a classic Wishbone master.
`timescale 1ns/1ps
module svf_core #(
   parameter bit MULTI = 1'b1 // 1: multichannel variant, 0: single-channel
) (
   input wire logic clk_i, // Master clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic chan_sel_hi_i, // Pairing select, upper bit
   input wire logic chan_sel_lo_i, // Pairing select, lower bit
   input wire logic polarity_select_i, // 1 unipolar, 0 bipolar
   input wire logic gain_i, // 0 gain one, 1 gain two
   input wire logic standby_n_i, // Standby when low
   input wire svf_pkg::svf_inputs_t analog_i, // Digitised input codes
   output logic pulse_output_o, // Frequency output
   output logic oscillator_out_o, // Clock presence indication
   output logic settled_o, // Output valid after settling
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [3:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   output logic wb_err_o // Wishbone error, unmapped address
);
   localparam int W = svf_pkg::ACC_W;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] pin_meta_reg;
   logic [4:0] pin_sync_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
      end else begin
         pin_meta_reg <= {chan_sel_hi_i, chan_sel_lo_i, polarity_select_i, gain_i,
                          standby_n_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   svf_pkg::svf_cfg_t cfg;
   logic standby_n;

   always_comb begin
      cfg.pair = svf_pkg::svf_pair_t'(pin_sync_reg[4:3]);
      cfg.polarity_select = pin_sync_reg[2];
      cfg.gain = pin_sync_reg[1];
      standby_n = pin_sync_reg[0];
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Bit 0 forces standby from software; bit 1 clears the pulse counter
   logic [31:0] ctrl_reg;
   logic soft_standby;
   logic run;

   assign soft_standby = ctrl_reg[0];
   assign run = standby_n && !soft_standby;

   // ----------------------------------------
   // Input selection and range
   // ----------------------------------------
   function automatic logic signed [W:0] sext(input logic [svf_pkg::SAMPLE_W-1:0] v);
      sext = (W+1)'(signed'(v));
   endfunction

   logic signed [W:0] vpos;
   logic signed [W:0] vneg;
   logic signed [W+1:0] diff;
   logic signed [W+2:0] scaled;
   logic signed [W+2:0] shifted;
   logic [W-1:0] level;
   logic signed [W+2:0] ref_s;

   always_comb begin
      vpos = sext(analog_i.analog_in_1);
      vneg = sext(analog_i.analog_in_4);
      if (MULTI) begin
         case (cfg.pair)
            svf_pkg::SVF_PAIR_1_4: begin
               vpos = sext(analog_i.analog_in_1);
               vneg = sext(analog_i.analog_in_4);
            end
            svf_pkg::SVF_PAIR_2_4: begin
               vpos = sext(analog_i.analog_in_2);
               vneg = sext(analog_i.analog_in_4);
            end
            svf_pkg::SVF_PAIR_3_4: begin
               vpos = sext(analog_i.analog_in_3);
               vneg = sext(analog_i.analog_in_4);
            end
            svf_pkg::SVF_PAIR_1_2: begin
               vpos = sext(analog_i.analog_in_1);
               vneg = sext(analog_i.analog_in_2);
            end
            default: begin
               vpos = sext(analog_i.analog_in_1);
               vneg = sext(analog_i.analog_in_4);
            end
         endcase
      end else begin
         vpos = sext(analog_i.analog_in_1);
         vneg = '0;
      end
      diff = (W+2)'(vpos) - (W+2)'(vneg);
      ref_s = (W+3)'(signed'({1'b0, svf_pkg::REF_CODE}));
      // Gain two doubles the input, halving the span
      if (MULTI && cfg.gain) begin
         scaled = (W+3)'(diff) <<< 1;
      end else begin
         scaled = (W+3)'(diff);
      end
      if (!MULTI || cfg.polarity_select) begin
         shifted = scaled;
      end else begin
         // Map -ref..+ref onto 0..ref
         shifted = (scaled + ref_s) >>> 1;
      end
      if (shifted < 0) begin
         level = '0;
      end else if (shifted > ref_s) begin
         level = svf_pkg::REF_CODE;
      end else begin
         level = W'(shifted);
      end
   end

   // ----------------------------------------
   // Modulator and output pulse
   // ----------------------------------------
   logic fire;

   svf_modulator u_mod (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .level_i(level),
      .fire_o(fire)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         pulse_output_o <= 1'b0;
      end else begin
         // Registered single-cycle pulse: starts on an edge, one clock wide
         pulse_output_o <= fire;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oscillator_out_o <= 1'b0;
      end else begin
         oscillator_out_o <= ~oscillator_out_o;
      end
   end

   // ----------------------------------------
   // Settling tracker
   // ----------------------------------------
   logic [3:0] settle_reg;
   logic [4:0] cfg_last_reg;
   logic [3:0] settle_len;

   assign settle_len = MULTI ? svf_pkg::SETTLE_MULTI : svf_pkg::SETTLE_SINGLE;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         settle_reg <= 4'h0;
         settled_o <= 1'b0;
      end else if (pin_sync_reg[4:1] != cfg_last_reg[4:1]) begin
         settle_reg <= 4'h0;
         settled_o <= 1'b0;
      end else if (settle_reg < settle_len) begin
         settle_reg <= settle_reg + 4'h1;
         settled_o <= (settle_reg + 4'h1) == settle_len;
      end else begin
         settled_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_last_reg <= 5'h00;
      end else begin
         cfg_last_reg <= pin_sync_reg;
      end
   end

   // ----------------------------------------
   // Pulse counter
   // ----------------------------------------
   logic [31:0] count_reg;
   logic wb_hit;
   logic wb_wr_ctrl;

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wb_wr_ctrl = wb_hit && wb_we_i && (wb_adr_i == svf_pkg::ADDR_CTRL);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= 32'h00000000;
      end else if (wb_wr_ctrl && wb_sel_i[0] && wb_dat_i[1]) begin
         count_reg <= 32'h00000000;
      end else if (fire && run) begin
         count_reg <= count_reg + 32'h00000001;
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= svf_pkg::CTRL_RESET;
      end else if (wb_wr_ctrl && wb_sel_i[0]) begin
         ctrl_reg <= {31'h00000000, wb_dat_i[0]};
      end
   end

   logic mapped;

   assign mapped = (wb_adr_i == svf_pkg::ADDR_STATUS) || (wb_adr_i == svf_pkg::ADDR_COUNT)
                || (wb_adr_i == svf_pkg::ADDR_CTRL);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_hit && mapped;
         wb_err_o <= wb_hit && !mapped;
         wb_dat_o <= 32'h00000000;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               svf_pkg::ADDR_STATUS: begin
                  wb_dat_o <= {25'h0000000, settled_o, run, cfg.pair,
                               cfg.polarity_select, cfg.gain, standby_n};
               end
               svf_pkg::ADDR_COUNT: begin
                  wb_dat_o <= count_reg;
               end
               svf_pkg::ADDR_CTRL: begin
                  wb_dat_o <= ctrl_reg;
               end
               default: begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
      end
   end
endmodule

/* File: hw/svf_pkg.sv */
// Shared constants and types for the synchronous pulse-output converter core.
// Assumes a 100 MHz system clock and digitised differential input codes.
package svf_pkg;

   // ----------------------------------------
   // Sample format
   // ----------------------------------------
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 18;
   // Full-scale code for one reference span
   localparam logic [ACC_W-1:0] REF_CODE = 18'h08000;

   // ----------------------------------------
   // Transfer constants
   // ----------------------------------------
   // Rate limits in units of 1/20 of the clock: 1/20 = 0.05, 9/20 = 0.45
   localparam logic [ACC_W-1:0] RATE_DEN = 18'h00014;
   localparam logic [ACC_W-1:0] RATE_MIN_NUM = 18'h00001;
   localparam logic [ACC_W-1:0] RATE_SPAN_NUM = 18'h00008;

   // ----------------------------------------
   // Settling
   // ----------------------------------------
   localparam logic [3:0] SETTLE_MULTI = 4'h2;
   localparam logic [3:0] SETTLE_SINGLE = 4'hA;

   // ----------------------------------------
   // Wishbone register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h4;
   localparam logic [3:0] ADDR_CTRL = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;

   // ----------------------------------------
   // Channel pairing
   // ----------------------------------------
   typedef enum logic [1:0] {
      SVF_PAIR_1_4 = 2'b00,
      SVF_PAIR_2_4 = 2'b01,
      SVF_PAIR_3_4 = 2'b10,
      SVF_PAIR_1_2 = 2'b11
   } svf_pair_t;

   typedef struct packed {
      svf_pair_t pair;
      logic polarity_select;
      logic gain;
   } svf_cfg_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] analog_in_1;
      logic [SAMPLE_W-1:0] analog_in_2;
      logic [SAMPLE_W-1:0] analog_in_3;
      logic [SAMPLE_W-1:0] analog_in_4;
   } svf_inputs_t;

endpackage

/* File: hw/svf_modulator.sv */
// First-order charge-balancing loop with a one-bit feedback step.
// Assumes its normalised input lies in 0 .. REF_CODE, one sample each clock.
`timescale 1ns/1ps
module svf_modulator (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic run_i, // Loop running
   input wire logic [svf_pkg::ACC_W-1:0] level_i, // Input 0 .. REF_CODE
   output logic fire_o // One-bit feedback decision
);
   // ----------------------------------------
   // Charge per cycle
   // ----------------------------------------
   // Add = min + level*span, decide when charge reaches one full quantum
   logic [svf_pkg::ACC_W+3:0] step;
   logic [svf_pkg::ACC_W+3:0] quantum;
   logic [svf_pkg::ACC_W+3:0] acc_reg;
   logic [svf_pkg::ACC_W+3:0] acc_next;

   always_comb begin
      step = {4'h0, svf_pkg::REF_CODE} * 22'(svf_pkg::RATE_MIN_NUM)
           + {4'h0, level_i} * 22'(svf_pkg::RATE_SPAN_NUM);
      quantum = {4'h0, svf_pkg::REF_CODE} * 22'(svf_pkg::RATE_DEN);
      acc_next = acc_reg + step;
      if (acc_next >= quantum) begin
         acc_next = acc_next - quantum;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         acc_reg <= '0;
         fire_o <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         fire_o <= (acc_reg + step) >= quantum;
      end
   end
endmodule

/* File: verification/svf_core_properties.sv */
// Port checker for the pulse-output converter core.
// Assumes a bind onto svf_core, one clock, sync reset.
`timescale 1ns/1ps
module svf_core_properties (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic standby_n_i, // Standby pin
   input wire logic pulse_output_o, // Pulses
   input wire logic oscillator_out_o, // Clock echo
   input wire logic settled_o, // Settled
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write
   input wire logic [3:0] wb_adr_i, // Address
   input wire logic [3:0] wb_sel_i, // Selects
   input wire logic [31:0] wb_dat_i, // Data
   input wire logic wb_ack_o, // Ack
   input wire logic wb_err_o // Error
);
   logic soft_reg;
   logic [5:0] gap_reg;
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_reg <= 1'b0;
      end else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[0]) begin
         soft_reg <= wb_dat_i[0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || pulse_output_o || !settled_o || soft_reg || !standby_n_i) begin
         gap_reg <= 6'h00;
      end else if (gap_reg != 6'h3F) begin
         gap_reg <= gap_reg + 6'h01;
      end
   end
   property p_pulse_one; pulse_output_o |=> !pulse_output_o; endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse too wide");
   property p_standby; !standby_n_i [*6] |-> !pulse_output_o; endproperty
   a_standby: assert property (p_standby) else $error("pulse in standby");
   property p_gap; gap_reg <= 6'h18; endproperty
   a_gap: assert property (p_gap) else $error("pulse rate too low");
   property p_osc;
      !$past(rst_i) && !$past(rst_i, 2) |-> oscillator_out_o != $past(oscillator_out_o);
   endproperty
   a_osc: assert property (p_osc) else $error("clock echo stuck");
   property p_ack; take |=> wb_ack_o ^ wb_err_o; endproperty
   a_ack: assert property (p_ack) else $error("no bus answer");
   property p_ack_one; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("answer too long");
   property p_err; take && wb_adr_i[3:2] == 2'b11 |=> wb_err_o; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
endmodule
bind svf_core svf_core_properties svf_core_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
   .standby_n_i(standby_n_i), .pulse_output_o(pulse_output_o),
   .oscillator_out_o(oscillator_out_o), .settled_o(settled_o), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

/* File: verification/svf_pulse_counter.sv */
// Gated counter standing at the far end of the pulse train.
// Assumes the gate is opened once the output has settled, or while the core is held in standby.
`timescale 1ns/1ps
module svf_pulse_counter (
   input wire logic clk_i, // Clock
   input wire logic pulse_i, // Pulse train
   input wire logic gate_i, // Count window
   output logic [15:0] count_o // Pulses seen
);
   always_ff @(posedge clk_i) begin
      if (!gate_i) begin
         count_o <= 16'h0000;
      end else if (pulse_i) begin
         count_o <= count_o + 16'h0001;
      end
   end
endmodule

/* File: verification/svf_core_tb.sv */
// Self-checking bench for the converter core.
// Assumes both variants side by side on one bus, pins and inputs.
`timescale 1ns/1ps
module svf_core_tb;
   localparam int N = 200;
   localparam int R = svf_pkg::REF_CODE;
   localparam int PP [4] = '{0, 1, 2, 0};
   localparam int NN [4] = '{3, 3, 3, 1};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] sel = 2'b00;
   logic uni = 1'b0;
   logic gain = 1'b0;
   logic stb_n = 1'b1;
   logic gate = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat, q;
   logic [15:0] a [4] = '{default: 16'h0000};
   logic pulse, ack, err, settled, e;
   logic [15:0] cnt, c;
   logic [15:0] cnt1, c1;
   logic pulse1, settled1;
   logic [3:0] be = 4'h0;
   logic [31:0] seed = 32'h46B97CCB;
   int fails = 0;
   int n_compared = 0;
   int ticks = 0;
   svf_pkg::svf_inputs_t ain;
   assign ain = {a[0], a[1], a[2], a[3]};
   always #5 clk_i = ~clk_i;
   svf_core svf_core_inst (.clk_i(clk_i), .rst_i(rst_i), .chan_sel_hi_i(sel[1]),
      .chan_sel_lo_i(sel[0]), .polarity_select_i(uni), .gain_i(gain), .standby_n_i(stb_n),
      .analog_i(ain), .pulse_output_o(pulse), .oscillator_out_o(), .settled_o(settled),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err));
   // Single-channel variant, its bus answers left to the checker
   svf_core #(.MULTI(1'b0)) svf_core_single_inst (.clk_i(clk_i), .rst_i(rst_i),
      .chan_sel_hi_i(sel[1]), .chan_sel_lo_i(sel[0]), .polarity_select_i(uni),
      .gain_i(gain), .standby_n_i(stb_n), .analog_i(ain), .pulse_output_o(pulse1),
      .oscillator_out_o(), .settled_o(settled1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(),
      .wb_ack_o(), .wb_err_o());
   svf_pulse_counter svf_pulse_counter_inst (.clk_i(clk_i), .pulse_i(pulse), .gate_i(gate),
      .count_o(cnt));
   svf_pulse_counter svf_pulse_counter_single_inst (.clk_i(clk_i), .pulse_i(pulse1),
      .gate_i(gate), .count_o(cnt1));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic int expc(input int p, input int n, input logic u, input logic g);
      int l;
      l = (p - n) * (g ? 2 : 1);
      if (!u) l = (l + R) / 2;
      if (l < 0) l = 0;
      if (l > R) l = R;
      return (N - 1) * (R + 8 * l) / (20 * R);
   endfunction
   task automatic conclude;
      if (fails == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] x, input int t);
      n_compared++;
      if ($isunknown(s) || s > x + t || s + t < x) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
      cyc <= 1'b1;
      be <= 4'hF;
      we <= w;
      adr <= ad;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      cyc <= 1'b0;
      be <= 4'h0;
      @(posedge clk_i);
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_i);
      while (settled !== 1'b1 || settled1 !== 1'b1) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
   endtask
   task automatic measure;
      gate <= 1'b1;
      repeat (N) @(posedge clk_i);
      c = cnt;
      c1 = cnt1;
      gate <= 1'b0;
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      ticks++;
      if (ticks > 20000) begin
         fails++;
         conclude;
      end
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, 4'h8, 32'h0);
      check(q, svf_pkg::CTRL_RESET, 0);
      bus(1'b0, 4'hC, 32'h0);
      check({31'h0, e}, 32'h1, 0);
      for (int i = 0; i < 16; i++) begin
         sel <= i[3:2];
         uni <= i[1];
         gain <= i[0];
         for (int j = 0; j < 4; j++) begin
            seed = xs(seed);
            a[j] <= (i == 0) ? 16'h0000 : seed[15:0];
         end
         settle;
         measure;
         check({16'h0, c}, expc($signed(a[PP[sel]]), $signed(a[NN[sel]]), uni, gain), 2);
         check({16'h0, c1}, expc($signed(a[0]), 0, 1'b1, 1'b0), 2);
         bus(1'b0, 4'h0, 32'h0);
         check({27'h0, q[4:0]}, {27'h0, sel, uni, gain, 1'b1}, 0);
      end
      bus(1'b1, 4'h8, 32'h1);
      measure;
      check({16'h0, c}, 32'h0, 0);
      check({16'h0, c1}, 32'h0, 0);
      bus(1'b1, 4'h8, 32'h0);
      settle;
      bus(1'b1, 4'h8, 32'h2);
      measure;
      bus(1'b0, 4'h4, 32'h0);
      check(q, {16'h0, c}, 3);
      bus(1'b0, 4'h8, 32'h0);
      check(q, 32'h0, 0);
      stb_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      measure;
      check({16'h0, c}, 32'h0, 0);
      check({16'h0, c1}, 32'h0, 0);
      check({31'h0, settled}, 32'h0, 0);
      check({31'h0, settled1}, 32'h0, 0);
      stb_n <= 1'b1;
      settle;
      measure;
      check({16'h0, c}, expc($signed(a[PP[sel]]), $signed(a[NN[sel]]), uni, gain), 2);
      check({16'h0, c1}, expc($signed(a[0]), 0, 1'b1, 1'b0), 2);
      conclude;
   end
endmodule
